// >>> eight_channel_pwm.v
// eight channel pwm with apb register access, prescaler, scalers and shutdown input
// assumes apb master on sys_clk_i; wait and freeze mode inputs come from the same clock
`timescale 1ns/1ps
`include "pwm_map.vh"

module eight_channel_pwm (
	input wire sys_clk_i,
	input wire rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	input wire wait_mode_i,
	input wire freeze_mode_i,
	input wire ch7_pin_i,
	output reg [7:0] pwm_o,
	output reg ch7_pin_oe_o,
	output reg irq_o
);
	// ********************************
	// functions
	// ********************************
	// mask of low prescaler bits for divide by 2^n
	function [6:0] div_mask;
		input [2:0] n;
		begin
			div_mask = `PRESC_ALL >> (`PRESC_MAX - n);
		end
	endfunction

	// scale value zero stands for the full count
	function [8:0] scale_limit;
		input [7:0] s;
		begin
			scale_limit = (s == `RST_BYTE) ? `SCALE_FULL : {1'b0, s};
		end
	endfunction

	// ********************************
	// registers
	// ********************************
	reg [7:0] channel_enable;
	reg [7:0] channel_polarity;
	reg [7:0] channel_clock_select;
	reg [2:0] prescale_a_select;
	reg [2:0] prescale_b_select;
	reg [7:0] center_align_enable;
	reg [5:0] control_bits;
	reg [7:0] scale_a_divisor;
	reg [7:0] scale_b_divisor;
	reg [7:0] period_buf [0:7];
	reg [7:0] duty_buf [0:7];
	reg shutdown_flag;
	reg shutdown_irq_enable;
	reg shutdown_output_level;
	reg ch7_active_level;
	reg ch7_shutdown_input_enable;
	reg shutdown_active;
	reg [7:0] irq_status;
	reg [7:0] irq_enable;
	reg [6:0] prescale_count;
	reg [8:0] scale_a_count;
	reg [8:0] scale_b_count;
	reg scale_a_phase;
	reg scale_b_phase;
	reg pin_meta;
	reg ch7_pin_state;
	reg [7:0] read_val;

	wire [5:0] idx = paddr_i[7:2];
	wire mapped = (paddr_i[1:0] == 2'b00) && (idx <= `RIX_LAST);
	wire access = psel_i & penable_i & pready_o;
	wire wr_en = access & pwrite_i & ~pslverr_o;
	wire [7:0] wbyte = pwdata_i[7:0];
	wire [5:0] off_cnt = idx - `RIX_COUNT0;
	wire [5:0] off_per = idx - `RIX_PERIOD0;
	wire [5:0] off_duty = idx - `RIX_DUTY0;
	wire in_cnt = (idx >= `RIX_COUNT0) && (off_cnt < `CHANNELS);
	wire in_per = (idx >= `RIX_PERIOD0) && (off_per < `CHANNELS);
	wire in_duty = (idx >= `RIX_DUTY0) && (off_duty < `CHANNELS);
	// pair k joins channels 2k and 2k+1
	wire [3:0] join_pair = control_bits[5:2];
	wire wait_clock_stop = control_bits[`CTL_WAIT];
	wire freeze_clock_stop = control_bits[`CTL_FREEZE];
	wire [127:0] chan_count;
	wire [7:0] chan_wave;
	wire [7:0] chan_end;
	wire [7:0] chan_tick;

	// ********************************
	// prescaler and scalers
	// ********************************
	// prescaler halts when idle, or in wait or freeze while its stop bit is set
	wire presc_run = (|channel_enable) & ~(wait_mode_i & wait_clock_stop) & ~(freeze_mode_i & freeze_clock_stop);
	wire [6:0] mask_a = div_mask(prescale_a_select);
	wire [6:0] mask_b = div_mask(prescale_b_select);
	wire tick_a = presc_run && ((prescale_count & mask_a) == mask_a);
	wire tick_b = presc_run && ((prescale_count & mask_b) == mask_b);
	wire wrap_a = scale_a_count == scale_limit(scale_a_divisor);
	wire wrap_b = scale_b_count == scale_limit(scale_b_divisor);
	// scaled clocks: one tick per two scaler wraps
	wire scaled_clock_a = tick_a & wrap_a & scale_a_phase;
	wire scaled_clock_b = tick_b & wrap_b & scale_b_phase;

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prescale_count <= 7'h00;
			scale_a_count <= `SCALE_START;
			scale_b_count <= `SCALE_START;
			scale_a_phase <= 1'b0;
			scale_b_phase <= 1'b0;
		end else begin
			if (presc_run)
				prescale_count <= prescale_count + 7'h01;
			// rewriting a divisor restarts its scaler so a new ratio takes hold at once
			if (wr_en && idx == `RIX_SCALE_A) begin
				scale_a_count <= `SCALE_START;
				scale_a_phase <= 1'b0;
			end else if (tick_a) begin
				scale_a_count <= wrap_a ? `SCALE_START : scale_a_count + 9'h001;
				scale_a_phase <= scale_a_phase ^ wrap_a;
			end
			if (wr_en && idx == `RIX_SCALE_B) begin
				scale_b_count <= `SCALE_START;
				scale_b_phase <= 1'b0;
			end else if (tick_b) begin
				scale_b_count <= wrap_b ? `SCALE_START : scale_b_count + 9'h001;
				scale_b_phase <= scale_b_phase ^ wrap_b;
			end
		end
	end

	// ********************************
	// channels
	// ********************************
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : ch
			wire joined = join_pair[i / 2];
			wire joined_hi = joined & (i % 2 == 1);
			wire joined_lo = joined & (i % 2 == 0);
			wire [15:0] per_in = joined_hi ? {period_buf[i ^ 1], period_buf[i]} : {8'h00, period_buf[i]};
			wire [15:0] duty_in = joined_hi ? {duty_buf[i ^ 1], duty_buf[i]} : {8'h00, duty_buf[i]};
			// writing a counter byte restarts the channel, in a pair either byte restarts it
			wire clr = wr_en && in_cnt && (off_cnt[2:0] == i || (joined_hi && off_cnt[2:0] == (i ^ 1)));
			// channels 0,1,4,5 use a/sa; 2,3,6,7 use b/sb
			if ((i / 2) % 2 == 0) begin : grp_a
				assign chan_tick[i] = channel_clock_select[i] ? scaled_clock_a : tick_a;
			end else begin : grp_b
				assign chan_tick[i] = channel_clock_select[i] ? scaled_clock_b : tick_b;
			end
			// one counter per channel, odd one 16 bits when joined
			// even half of a joined pair stays disabled
			pwm_channel u_chan (
				.sys_clk_i(sys_clk_i),
				.rst_i(rst_i),
				.tick_i(chan_tick[i]),
				.enable_i(channel_enable[i] & ~joined_lo),
				.polarity_i(channel_polarity[i]),
				.center_i(center_align_enable[i]),
				.clear_i(clr),
				.period_i(per_in),
				.duty_i(duty_in),
				.count_o(chan_count[i * 16 +: 16]),
				.wave_o(chan_wave[i]),
				.period_end_o(chan_end[i])
			);
		end
	endgenerate

	// ********************************
	// shutdown input
	// ********************************
	// pin sampled through two flops
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta <= 1'b0;
			ch7_pin_state <= 1'b0;
		end else begin
			pin_meta <= ch7_pin_i;
			ch7_pin_state <= pin_meta;
		end
	end

	wire shutdown_hit = ch7_shutdown_input_enable && (ch7_pin_state == ch7_active_level);

	// ********************************
	// register read mux
	// ********************************
	// reserved bits and test registers read zero
	always @* begin
		read_val = `RST_BYTE;
		if (in_cnt) begin
			if (join_pair[off_cnt[2:1]] && !off_cnt[0])
				read_val = chan_count[{off_cnt[2:0] | 3'h1, 4'h8} +: 8];
			else
				read_val = chan_count[{off_cnt[2:0], 4'h0} +: 8];
		end else if (in_per)
			read_val = period_buf[off_per[2:0]];
		else if (in_duty)
			read_val = duty_buf[off_duty[2:0]];
		else begin
			case (idx)
				`RIX_ENABLE: read_val = channel_enable;
				`RIX_POLARITY: read_val = channel_polarity;
				`RIX_CLOCK_SEL: read_val = channel_clock_select;
				`RIX_PRESCALE: read_val = {1'b0, prescale_b_select, 1'b0, prescale_a_select};
				`RIX_CENTER: read_val = center_align_enable;
				`RIX_CONTROL: read_val = {control_bits, 2'b00};
				`RIX_SCALE_A: read_val = scale_a_divisor;
				`RIX_SCALE_B: read_val = scale_b_divisor;
				`RIX_SHUTDOWN: read_val = {shutdown_flag, shutdown_irq_enable, 1'b0, shutdown_output_level,
					1'b0, ch7_pin_state, ch7_active_level, ch7_shutdown_input_enable};
				`RIX_IRQ_STATUS: read_val = irq_status;
				`RIX_IRQ_ENABLE: read_val = irq_enable;
				default: read_val = `RST_BYTE;
			endcase
		end
	end

	// ********************************
	// apb slave and register writes
	// ********************************
	// fixed map decoded from index zero
	integer k;
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			channel_enable <= `RST_BYTE;
			channel_polarity <= `RST_BYTE;
			channel_clock_select <= `RST_BYTE;
			prescale_a_select <= 3'h0;
			prescale_b_select <= 3'h0;
			center_align_enable <= `RST_BYTE;
			control_bits <= 6'h00;
			scale_a_divisor <= `RST_BYTE;
			scale_b_divisor <= `RST_BYTE;
			for (k = 0; k < 8; k = k + 1) begin
				period_buf[k] <= `RST_PERIOD;
				duty_buf[k] <= `RST_BYTE;
			end
			shutdown_irq_enable <= 1'b0;
			shutdown_output_level <= 1'b0;
			ch7_active_level <= 1'b0;
			ch7_shutdown_input_enable <= 1'b0;
			irq_enable <= `RST_BYTE;
		end else begin
			// one wait-free answer: data and error latched in the setup cycle
			pready_o <= psel_i & ~penable_i;
			pslverr_o <= psel_i & ~penable_i & ~mapped;
			if (psel_i & ~penable_i)
				prdata_o <= {24'h000000, read_val};
			if (wr_en) begin
				if (in_per)
					period_buf[off_per[2:0]] <= wbyte;
				if (in_duty)
					duty_buf[off_duty[2:0]] <= wbyte;
				case (idx)
					`RIX_ENABLE: channel_enable <= wbyte;
					`RIX_POLARITY: channel_polarity <= wbyte;
					`RIX_CLOCK_SEL: channel_clock_select <= wbyte;
					`RIX_PRESCALE: begin
						prescale_a_select <= wbyte[`PRESCALE_A_SELECT_LSB +: 3];
						prescale_b_select <= wbyte[`PRESCALE_B_SELECT_LSB +: 3];
					end
					`RIX_CENTER: center_align_enable <= wbyte;
					`RIX_CONTROL: control_bits <= wbyte[7:`CTL_LSB];
					`RIX_SCALE_A: scale_a_divisor <= wbyte;
					`RIX_SCALE_B: scale_b_divisor <= wbyte;
					`RIX_SHUTDOWN: begin
						shutdown_irq_enable <= wbyte[`SD_IE];
						shutdown_output_level <= wbyte[`SD_LEVEL];
						ch7_active_level <= wbyte[`SD_ACT_LEVEL];
						ch7_shutdown_input_enable <= wbyte[`SD_IN_EN];
					end
					`RIX_IRQ_ENABLE: irq_enable <= wbyte;
					default: ;
				endcase
			end
		end
	end

	// ********************************
	// events, shutdown state, interrupt
	// ********************************
	wire clr_sd_flag = wr_en && idx == `RIX_SHUTDOWN && wbyte[`SD_FLAG];
	wire restart = wr_en && idx == `RIX_SHUTDOWN && wbyte[`SD_RESTART];
	wire [7:0] status_clear = (wr_en && idx == `RIX_IRQ_CLEAR) ? wbyte : `RST_BYTE;

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			shutdown_flag <= 1'b0;
			shutdown_active <= 1'b0;
			irq_status <= `RST_BYTE;
			irq_o <= 1'b0;
		end else begin
			// set wins over a clear in the same cycle
			shutdown_flag <= shutdown_hit | (shutdown_flag & ~clr_sd_flag);
			// restart only takes once the pin has gone inactive
			if (shutdown_hit)
				shutdown_active <= 1'b1;
			else if (restart)
				shutdown_active <= 1'b0;
			irq_status <= chan_end | (irq_status & ~status_clear);
			irq_o <= (|(irq_status & irq_enable)) | (shutdown_flag & shutdown_irq_enable);
		end
	end

	// ********************************
	// pin outputs
	// ********************************
	integer j;
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_o <= `RST_BYTE;
			ch7_pin_oe_o <= 1'b1;
		end else begin
			for (j = 0; j < 8; j = j + 1) begin
				if (join_pair[j / 2] && (j % 2 == 0))
					pwm_o[j] <= 1'b0;
				else if (shutdown_active)
					pwm_o[j] <= shutdown_output_level;
				else
					pwm_o[j] <= chan_wave[j];
			end
			// pin 7 turns input while shutdown input enabled
			if (ch7_shutdown_input_enable)
				pwm_o[7] <= 1'b0;
			ch7_pin_oe_o <= ~ch7_shutdown_input_enable;
		end
	end

endmodule // eight_channel_pwm

// >>> eight_channel_pwm_bench.sv
// self-checking bench for the eight channel pwm
// assumes the design answers apb in the access phase; the bench drives every port
`timescale 1ns/1ps
module eight_channel_pwm_bench;
	reg sys_clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg psel_i = 1'b0;
	reg penable_i = 1'b0;
	reg pwrite_i = 1'b0;
	reg [7:0] paddr_i = 8'h00;
	reg [31:0] pwdata_i = 32'h0;
	reg wait_mode_i = 1'b0;
	reg freeze_mode_i = 1'b0;
	reg ch7_pin_i = 1'b1;
	wire [31:0] prdata_o;
	wire pready_o;
	wire pslverr_o;
	wire [7:0] pwm_o;
	wire ch7_pin_oe_o;
	wire irq_o;
	integer err_total = 0;
	integer samples_checked = 0;
	integer cyc = 0;
	integer i, hi, rs, p, d, r;
	reg [31:0] rd;
	reg er;

	eight_channel_pwm uut (.*);

	always #10 sys_clk_i = ~sys_clk_i;
	// ends a run still going at cycle 60000 and counts it as an error
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total = err_total + 1;
			summarize;
		end
	end

	task check(input [31:0] seen, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
			end
		end
	endtask

	task summarize;
		begin
			$display("compares %0d mismatches %0d", samples_checked, err_total);
			if (err_total == 0 && samples_checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask

	// ********************************
	// bus and waveform helpers
	// ********************************
	task apb(input w, input [7:0] a, input [7:0] v);
		integer n;
		begin
			@(posedge sys_clk_i);
			psel_i <= 1'b1;
			pwrite_i <= w;
			paddr_i <= a;
			pwdata_i <= {24'h0, v};
			@(posedge sys_clk_i);
			penable_i <= 1'b1;
			n = 0;
			do begin
				@(posedge sys_clk_i);
				n = n + 1;
			end while (pready_o !== 1'b1 && n < 20);
			if (n == 20)
				err_total = err_total + 1;
			rd = prdata_o;
			er = pslverr_o;
			psel_i <= 1'b0;
			penable_i <= 1'b0;
		end
	endtask

	task wr(input [5:0] a, input [7:0] v);
		apb(1'b1, {a, 2'b00}, v);
	endtask

	task rc(input [5:0] a, input [7:0] v);
		begin
			apb(1'b0, {a, 2'b00}, 8'h00);
			check(rd, {24'h0, v});
		end
	endtask

	task meas(input integer ch, input integer n);
		reg q;
		begin
			hi = 0;
			rs = 0;
			q = pwm_o[ch];
			repeat (n) begin
				@(posedge sys_clk_i);
				hi = hi + pwm_o[ch];
				rs = rs + (pwm_o[ch] & ~q);
				q = pwm_o[ch];
			end
		end
	endtask

	function integer hexp(input integer pol, input integer dd, input integer pp, input integer m);
		integer k;
		begin
			k = (dd > pp) ? pp : dd;
			hexp = m * (pol ? k : pp - k);
		end
	endfunction

	function [7:0] wmask(input integer a);
		case (a)
			3: wmask = 8'h77;
			5: wmask = 8'hFC;
			6, 7, 10, 11: wmask = 8'h00;
			default: wmask = 8'hFF;
		endcase
	endfunction

	// the first periods after enable may be irregular, so measuring waits three
	task run(input integer ch, input integer pol, input integer cae, input integer pre, input integer sc);
		integer div, len;
		reg [7:0] m;
		begin
			m = 8'h01 << ch;
			div = (1 << pre) * (sc ? 2 * sc : 1);
			len = (cae ? 2 * p : p) * div;
			wr(6'h01, pol ? m : 8'h00);
			wr(6'h02, sc ? m : 8'h00);
			wr(6'h04, cae ? m : 8'h00);
			wr(6'h03, 8'(pre << (ch[1] ? 4 : 0)));
			wr(ch[1] ? 6'h09 : 6'h08, 8'(sc));
			wr(6'h14 + 6'(ch), 8'(p));
			wr(6'h1C + 6'(ch), 8'(d));
			wr(6'h00, m);
			repeat (3 * len) @(posedge sys_clk_i);
			meas(ch, 4 * len);
			check(rs, (d == 0 || (!cae && d >= p)) ? 0 : 4);
			if (!cae)
				check(hi, hexp(pol, d, p, 4 * div));
			wr(6'h00, 8'h00);
		end
	endtask

	initial begin
		r = $urandom(32'h647425f1);
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 40; i = i + 1)
			rc(6'(i), (i >= 20 && i < 28) ? 8'hFF : (i == 36) ? 8'h04 : 8'h00);
		for (i = 0; i < 12; i = i + 1) begin
			r = $urandom;
			wr(6'(i), 8'(r));
			rc(6'(i), 8'(r) & wmask(i));
			wr(6'(i), 8'h00);
		end
		apb(1'b0, {6'h28 + 6'($urandom % 24), 2'b00}, 8'h00);
		check(er, 1'b1);
		check(rd, 32'h0);
		apb(1'b1, 8'h01, 8'hFF);
		check(er, 1'b1);
		rc(6'h00, 8'h00);
		$display("register map test done");
		for (i = 0; i < 8; i = i + 1) begin
			p = 4 + $urandom % 12;
			d = (i == 0) ? 0 : (i == 1) ? p : (i == 2) ? p + 5 : 1 + $urandom % (p - 1);
			run(i, i % 2, i == 3 || i == 6, i % 3, (i == 5) ? 2 : 0);
			$display("waveform test %0d done", i);
		end
		wr(6'h02, 8'h00);
		wr(6'h03, 8'h00);
		wr(6'h04, 8'h00);
		wr(6'h01, 8'h02);
		wr(6'h05, 8'h10);
		wr(6'h14, 8'h01);
		wr(6'h15, 8'h04);
		wr(6'h1C, 8'h00);
		wr(6'h1D, 8'h82);
		wr(6'h00, 8'h03);
		repeat (600) @(posedge sys_clk_i);
		meas(1, 520);
		check(hi, hexp(1, 130, 260, 2));
		meas(0, 100);
		check(hi, 0);
		wr(6'h00, 8'h00);
		wr(6'h05, 8'h00);
		wr(6'h14, 8'h04);
		wr(6'h1C, 8'h02);
		wr(6'h00, 8'h01);
		$display("joined pair test done");
		for (i = 0; i < 3; i = i + 1) begin
			wr(6'h05, (i == 0) ? 8'h08 : (i == 1) ? 8'h04 : 8'h00);
			wait_mode_i <= (i == 0);
			freeze_mode_i <= (i != 0);
			repeat (8) @(posedge sys_clk_i);
			meas(0, 16);
			check(rs, (i == 2) ? 4 : 0);
		end
		$display("clock stop test done");
		wr(6'h27, 8'hFF);
		repeat (20) @(posedge sys_clk_i);
		rc(6'h25, 8'h01);
		check(irq_o, 1'b0);
		wr(6'h26, 8'h01);
		repeat (3) @(posedge sys_clk_i);
		check(irq_o, 1'b1);
		wr(6'h00, 8'h00);
		wr(6'h27, 8'h01);
		rc(6'h25, 8'h00);
		check(irq_o, 1'b0);
		$display("interrupt test done");
		wr(6'h24, 8'h01);
		repeat (4) @(posedge sys_clk_i);
		rc(6'h24, 8'h05);
		check(ch7_pin_oe_o, 1'b0);
		ch7_pin_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		rc(6'h24, 8'h81);
		ch7_pin_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		wr(6'h24, 8'hA1);
		rc(6'h24, 8'h05);
		wr(6'h24, 8'h00);
		repeat (3) @(posedge sys_clk_i);
		check(ch7_pin_oe_o, 1'b1);
		$display("shutdown test done");
		summarize;
	end
endmodule // eight_channel_pwm_bench

// >>> pwm_channel.v
// one pwm channel: counter, active period/duty copies and waveform flop
// assumes tick_i is a one-cycle pulse from the selected clock source
`timescale 1ns/1ps
`include "pwm_map.vh"

module pwm_channel (
	input wire sys_clk_i,
	input wire rst_i,
	input wire tick_i,
	input wire enable_i,
	input wire polarity_i,
	input wire center_i,
	input wire clear_i,
	input wire [15:0] period_i,
	input wire [15:0] duty_i,
	output wire [15:0] count_o,
	output wire wave_o,
	output wire period_end_o
);
	reg [15:0] count;
	reg [15:0] per_act;
	reg [15:0] duty_act;
	reg down;
	reg running;
	reg wave;
	reg period_end;
	reg [15:0] next_count;
	reg next_down;
	reg reload;

	// ********************************
	// count sequence
	// ********************************
	// left wraps, center reverses
	always @* begin
		next_count = count + `ONE16;
		next_down = down;
		reload = 1'b0;
		if (!center_i) begin
			if (per_act == `RST_WORD || count >= per_act - `ONE16) begin
				next_count = `RST_WORD;
				reload = 1'b1;
			end
		end else if (!down) begin
			if (count >= per_act) begin
				if (count == `RST_WORD) begin
					next_count = `RST_WORD;
					reload = 1'b1;
				end else begin
					next_count = count - `ONE16;
					next_down = 1'b1;
				end
			end
		end else begin
			next_count = count - `ONE16;
			if (count <= `ONE16) begin
				next_count = `RST_WORD;
				next_down = 1'b0;
				reload = 1'b1;
			end
		end
	end

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= `RST_WORD;
			per_act <= `RST_WORD;
			duty_act <= `RST_WORD;
			down <= 1'b0;
			running <= 1'b0;
			wave <= 1'b0;
			period_end <= 1'b0;
		end else begin
			period_end <= 1'b0;
			if (!enable_i) begin
				count <= `RST_WORD;
				down <= 1'b0;
				running <= 1'b0;
				wave <= 1'b0;
				per_act <= period_i;
				duty_act <= duty_i;
			end else if (clear_i) begin
				count <= `RST_WORD;
				down <= 1'b0;
				per_act <= period_i;
				duty_act <= duty_i;
			end else if (tick_i) begin
				running <= 1'b1;
				if (!running) begin
					count <= `RST_WORD;
					wave <= (duty_act != `RST_WORD) ? polarity_i : ~polarity_i;
				end else begin
					count <= next_count;
					down <= next_down;
					period_end <= reload;
					if (reload) begin
						per_act <= period_i;
						duty_act <= duty_i;
					end
					wave <= (next_count < (reload ? duty_i : duty_act)) ? polarity_i : ~polarity_i;
				end
			end
		end
	end

	assign count_o = count;
	assign wave_o = wave;
	assign period_end_o = period_end;

endmodule // pwm_channel

// >>> pwm_map.vh
// register indices, field positions, reset values and fixed counts of the eight channel pwm
// assumes a 32-bit apb slave: byte address = index * 4, data in the low byte
//
// Notes on behaviour
// - eight channels, own counter, period, duty
// - period/duty buffered, loaded at zero or disabled
// - eight 8-bit or four joined 16-bit channels
// - clocks a, b and scaled sa, sb
// - per-channel left or center alignment
// - per-channel duty pulse polarity
// - duty from constant inactive to constant active
// - per-channel enable; disabled channel stays low except while shutdown drives its output level
// - wait mode option stops prescaler clock
// - freeze mode option stops prescaler clock
// - channel 7 pin doubles as shutdown input
// - reserved bits read zero, writes ignored
// - fixed register map from offset zero
// - waveform starts at next source clock tick
// - polarity one: high first, low at duty
// - joined pair uses odd enable, even pin off
// - prescaler stops while all channels disabled
`ifndef PWM_MAP_VH
`define PWM_MAP_VH

// ********************************
// register indices
// ********************************
`define RIX_ENABLE 6'h00
`define RIX_POLARITY 6'h01
`define RIX_CLOCK_SEL 6'h02
`define RIX_PRESCALE 6'h03
`define RIX_CENTER 6'h04
`define RIX_CONTROL 6'h05
`define RIX_SCALE_A 6'h08
`define RIX_SCALE_B 6'h09
`define RIX_COUNT0 6'h0C
`define RIX_PERIOD0 6'h14
`define RIX_DUTY0 6'h1C
`define RIX_SHUTDOWN 6'h24
`define RIX_IRQ_STATUS 6'h25
`define RIX_IRQ_ENABLE 6'h26
`define RIX_IRQ_CLEAR 6'h27
`define RIX_LAST 6'h27
`define CHANNELS 6'h08

// ********************************
// fields
// ********************************
`define PRESCALE_A_SELECT_LSB 0
`define PRESCALE_B_SELECT_LSB 4
`define CTL_LSB 2
`define CTL_WAIT 1
`define CTL_FREEZE 0
`define SD_FLAG 7
`define SD_IE 6
`define SD_RESTART 5
`define SD_LEVEL 4
`define SD_PIN 2
`define SD_ACT_LEVEL 1
`define SD_IN_EN 0

// ********************************
// reset values and counts
// ********************************
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_PERIOD 8'hFF
`define PRESC_ALL 7'h7F
`define PRESC_MAX 3'h7
`define SCALE_FULL 9'h100
`define SCALE_START 9'h001
`define ONE16 16'h0001

`endif

// >>> pwm_props.sv
// assertions on the eight channel pwm ports
// assumes an apb master on sys_clk_i; a few registers are shadowed from bus writes
`timescale 1ns/1ps
module pwm_props (
	input wire sys_clk_i,
	input wire rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o,
	input wire wait_mode_i,
	input wire freeze_mode_i,
	input wire ch7_pin_i,
	input wire [7:0] pwm_o,
	input wire ch7_pin_oe_o,
	input wire irq_o
);
	reg [7:0] en;
	reg [7:0] ctl;
	reg [7:0] ie;
	reg [7:0] sd;
	wire wr = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
	wire [7:0] jm = {1'b0, ctl[7], 1'b0, ctl[6], 1'b0, ctl[5], 1'b0, ctl[4]};
	wire [7:0] off = ~en | jm;
	wire stop = (wait_mode_i & ctl[3]) | (freeze_mode_i & ctl[2]);
	// shadows follow accepted writes only, so refused ones cannot skew them
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			en <= 8'h00;
			ctl <= 8'h00;
			ie <= 8'h00;
			sd <= 8'h00;
		end else if (wr) begin
			case (paddr_i)
				8'h00: en <= pwdata_i[7:0];
				8'h14: ctl <= pwdata_i[7:0];
				8'h90: sd <= pwdata_i[7:0];
				8'h98: ie <= pwdata_i[7:0];
				default: ;
			endcase
		end
	end
	// ********************************
	// properties
	// ********************************
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready after setup");
	a_ready_has_cause: assert property (pready_o |-> $past(psel_i && !penable_i))
		else $error("ready without setup");
	a_upper_read_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_err_bad_addr: assert property (pready_o && (paddr_i[1:0] != 2'h0 || paddr_i[7:2] > 6'h27) |-> pslverr_o)
		else $error("bad address not refused");
	a_reserved_read_zero: assert property (pready_o && !pwrite_i && paddr_i inside {8'h18, 8'h1C, 8'h28, 8'h2C}
		|-> prdata_o == 32'h0)
		else $error("test register reads nonzero");
	a_disabled_low: assert property ((pwm_o & off & $past(off) & $past(off, 2)) == 8'h00)
		else $error("disabled channel drives high");
	a_joined_even_low: assert property ((pwm_o & jm & $past(jm) & $past(jm, 2)) == 8'h00)
		else $error("joined upper pin active");
	a_stop_holds_wave: assert property (stop && $past(stop) && $past(stop, 2) && $past(stop, 3) |-> $stable(pwm_o))
		else $error("waveform moved while clock stopped");
	a_irq_needs_enable: assert property (irq_o |-> $past(ie != 8'h00 || sd[6]))
		else $error("irq without enable");
	a_pin_oe_follow: assert property ($past(sd[0]) == sd[0] && $past(sd[0], 2) == sd[0] |-> ch7_pin_oe_o != sd[0])
		else $error("pin 7 drive wrong");
endmodule // pwm_props

bind eight_channel_pwm pwm_props u_props (.*);
